// File: efr_consts.svh
`ifndef EFR_CONSTS_SVH
`define EFR_CONSTS_SVH
`define EFR_REC_SIZE        16
`define EFR_REC_ADDR_OFS    0
`define EFR_REC_ERR_OFS     8
`define EFR_REC_RSV_OFS     12
`define EFR_PPD_ALIGN       32
`define EFR_PPD_LIN_OFS     0
`define EFR_PPD_SRC_OFS     8
`define EFR_PPD_META_OFS    16
`define EFR_PPD_CTL_OFS     24
`define EFR_EC_P            0
`define EFR_EC_WR           1
`define EFR_EC_US           2
`define EFR_EC_RSVD         3
`define EFR_EC_ID           4
`define EFR_EC_PK           5
`define EFR_EC_MAP          15
`define EFR_FL_R            0
`define EFR_FL_W            1
`define EFR_FL_X            2
`define EFR_FL_PEND         3
`define EFR_FL_MOD          4
`define EFR_FL_PR           5
`define EFR_FL_TYPE_LO      8
`define EFR_FL_RSV_MASK     64'hFFFF_FFFF_FFFF_00C0
`define EFR_TYPE_MAX        8'h04
// bus register word offsets
`define EFR_REG_CAP         4'h0
`define EFR_REG_SEL         4'h1
`define EFR_REG_GPR_OFS     4'h2
`define EFR_REG_MSIZE       4'h3
`define EFR_REG_MBASE       4'h4
`define EFR_REG_STAT        4'h5
`define EFR_REG_ADDR_LO     4'h6
`define EFR_REG_ADDR_HI     4'h7
`define EFR_REG_FAULT_ERROR_CODE       4'h8
`define EFR_REG_FLAGS_LO    4'h9
`define EFR_REG_FLAGS_HI    4'hA
`define EFR_REG_DEC         4'hB
`define EFR_REG_PPD         4'hC
`define EFR_CAP_RST         32'h0000_0001
`define EFR_GPR_OFS_RST     32'h0000_0100
`endif

// File: efr_pkg.sv
package efr_pkg;
  typedef enum logic [1:0] {
    EFR_NONE,
    EFR_GP,
    EFR_PF
  } efr_fault_t;

  typedef struct packed {
    logic        valid;
    efr_fault_t  kind;
    logic [63:0] lin_addr;
    logic        present;
    logic        write;
    logic        user;
    logic        rsvd_bit;
    logic        fetch;
    logic        pkey;
    logic        map_fault;
    logic [15:0] gp_code;
  } efr_fault_in_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] frame_ofs;
    logic [63:0] lin_addr;
    logic [31:0] err_code;
    logic [31:0] reserved;
  } efr_record_t;

  typedef struct packed {
    logic       ok;
    logic       rd;
    logic       wr;
    logic       ex;
    logic       pending;
    logic       page_flag_a;
    logic       restrict_busy;
    logic [7:0] page_type;
  } efr_flag_dec_t;
endpackage

// File: efr_flag_decode.sv
`timescale 1ns/1ps
`include "efr_consts.svh"
module efr_flag_decode
  import efr_pkg::*;
(
  // descriptor flags word
  input  wire logic [63:0] flags,
  // decoded view
  output efr_flag_dec_t    dec
);
  logic [7:0] ptype;
  assign ptype = flags[`EFR_FL_TYPE_LO +: 8];
  always_comb begin
    dec.rd            = flags[`EFR_FL_R];
    dec.wr            = flags[`EFR_FL_W];
    dec.ex            = flags[`EFR_FL_X];
    dec.pending       = flags[`EFR_FL_PEND];
    dec.page_flag_a      = flags[`EFR_FL_MOD];
    dec.restrict_busy = flags[`EFR_FL_PR];
    dec.page_type     = ptype;
    dec.ok            = ((flags & `EFR_FL_RSV_MASK) == 64'h0000_0000_0000_0000)
                        && (ptype <= `EFR_TYPE_MAX);
  end
endmodule

// File: efr_recorder.sv
`timescale 1ns/1ps
`include "efr_consts.svh"
module efr_recorder
  import efr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // fault report from the core
  input  efr_fault_in_t    fault_in,
  // record write toward the save frame
  output efr_record_t      rec_out
);
  // registers
  logic [31:0]   cap_mask;
  logic [31:0]   component_select_mask;
  logic [31:0]   gpr_ofs;
  logic [63:0]   flags_word;
  logic [63:0]   ppd_addr;
  logic [31:0]   rec_count;
  logic [31:0]   drop_count;
  efr_record_t   last_rec;
  logic          acc_done;
  logic [31:0]   rdata;
  logic [31:0]   next_cap_mask;
  logic [31:0]   next_sel;
  logic [31:0]   next_gpr_ofs;
  logic [63:0]   next_flags_word;
  logic [63:0]   next_ppd_addr;
  logic [31:0]   next_rec_count;
  logic [31:0]   next_drop_count;
  efr_record_t   next_last_rec;
  efr_record_t   next_rec_out;
  logic          next_acc_done;
  logic [31:0]   next_rdata;
  logic          next_wait;
  efr_flag_dec_t fdec;
  logic [31:0]   misc_size;
  logic [31:0]   misc_base;
  logic [31:0]   pf_code;
  logic          enabled;
  logic          ppd_aligned;

  efr_flag_decode u_dec (
    .flags (flags_word),
    .dec   (fdec)
  );

  // size of a defined component; later components have no size yet
  function automatic logic [31:0] comp_size(input int idx);
    comp_size = (idx == 0) ? 32'(`EFR_REC_SIZE) : 32'h0000_0000;
  endfunction

  // highest selected and capable component offset below the register area plus its size
  always_comb begin
    misc_size = 32'h0000_0000;
    if (cap_mask != 32'h0000_0000) begin
      for (int i = 0; i < 32; i++) begin
        if (component_select_mask[i] && cap_mask[i]) begin
          misc_size = 32'(`EFR_REC_SIZE) * 32'(i + 1) - 32'(`EFR_REC_SIZE)
                      + comp_size(i);
        end
      end
    end
  end
  assign misc_base = gpr_ofs - misc_size;

  // exception record enabled only when both capability and select agree
  assign enabled = cap_mask[0] && component_select_mask[0];

  always_comb begin
    pf_code                = 32'h0000_0000;
    pf_code[`EFR_EC_P]     = fault_in.present;
    pf_code[`EFR_EC_WR]    = fault_in.write;
    pf_code[`EFR_EC_US]    = 1'b1;
    pf_code[`EFR_EC_RSVD]  = fault_in.rsvd_bit;
    pf_code[`EFR_EC_ID]    = fault_in.fetch;
    pf_code[`EFR_EC_PK]    = fault_in.pkey;
    pf_code[`EFR_EC_MAP]   = fault_in.map_fault;
  end

  assign ppd_aligned = (ppd_addr[4:0] == 5'h00);

  // fault capture
  always_comb begin
    next_rec_out       = '0;
    next_last_rec      = last_rec;
    next_rec_count     = rec_count;
    next_drop_count    = drop_count;
    if (fault_in.valid && fault_in.kind != EFR_NONE) begin
      if (!enabled || (fault_in.kind == EFR_PF && !fault_in.user)) begin
        next_drop_count = drop_count + 32'h0000_0001;
      end else begin
        next_rec_out.valid     = 1'b1;
        next_rec_out.frame_ofs = gpr_ofs - 32'(`EFR_REC_SIZE);
        next_rec_out.reserved  = 32'h0000_0000;
        if (fault_in.kind == EFR_PF) begin
          next_rec_out.lin_addr = fault_in.lin_addr;
          next_rec_out.err_code = pf_code;
        end else begin
          next_rec_out.lin_addr = 64'h0000_0000_0000_0000;
          next_rec_out.err_code = {16'h0000, fault_in.gp_code};
        end
        next_last_rec  = next_rec_out;
        next_rec_count = rec_count + 32'h0000_0001;
      end
    end
  end

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    merge = r;
  endfunction

  // bus slave: one wait cycle, answer on the second
  always_comb begin
    next_cap_mask   = cap_mask;
    next_sel        = component_select_mask;
    next_gpr_ofs    = gpr_ofs;
    next_flags_word = flags_word;
    next_ppd_addr   = ppd_addr;
    next_rdata      = rdata;
    next_acc_done   = 1'b0;
    next_wait       = 1'b1;
    if ((avs_read || avs_write) && !acc_done) begin
      next_acc_done = 1'b1;
      next_wait     = 1'b0;
      next_rdata    = 32'h0000_0000;
      if (avs_read && avs_address[5:4] == 2'b00) begin
        case (avs_address[3:0])
          `EFR_REG_CAP:      next_rdata = cap_mask;
          `EFR_REG_SEL:      next_rdata = component_select_mask;
          `EFR_REG_GPR_OFS:  next_rdata = gpr_ofs;
          `EFR_REG_MSIZE:    next_rdata = misc_size;
          `EFR_REG_MBASE:    next_rdata = misc_base;
          `EFR_REG_STAT:     next_rdata = {rec_count[15:0], drop_count[15:0]};
          `EFR_REG_ADDR_LO:  next_rdata = last_rec.lin_addr[31:0];
          `EFR_REG_ADDR_HI:  next_rdata = last_rec.lin_addr[63:32];
          `EFR_REG_FAULT_ERROR_CODE:    next_rdata = last_rec.err_code;
          `EFR_REG_FLAGS_LO: next_rdata = flags_word[31:0];
          `EFR_REG_FLAGS_HI: next_rdata = flags_word[63:32];
          `EFR_REG_DEC:      next_rdata = {fdec.page_type, 16'h0000, ppd_aligned, fdec.ok,
                                           fdec.restrict_busy, fdec.page_flag_a, fdec.pending,
                                           fdec.ex, fdec.wr, fdec.rd};
          `EFR_REG_PPD:      next_rdata = ppd_addr[31:0];
          default:           next_rdata = 32'h0000_0000;
        endcase
      end
    end
    // writes land at the edge where the master sees waitrequest low; aliases ignored
    if (avs_write && acc_done && avs_address[5:4] == 2'b00) begin
        case (avs_address[3:0])
          `EFR_REG_CAP:      next_cap_mask   = merge(cap_mask, avs_writedata, avs_byteenable);
          `EFR_REG_SEL:      next_sel        = merge(component_select_mask, avs_writedata,
                                                     avs_byteenable);
          `EFR_REG_GPR_OFS:  next_gpr_ofs    = merge(gpr_ofs, avs_writedata, avs_byteenable);
          `EFR_REG_FLAGS_LO: next_flags_word[31:0]  = merge(flags_word[31:0], avs_writedata,
                                                            avs_byteenable);
          `EFR_REG_FLAGS_HI: next_flags_word[63:32] = merge(flags_word[63:32], avs_writedata,
                                                            avs_byteenable);
          `EFR_REG_PPD:      next_ppd_addr[31:0] = merge(ppd_addr[31:0], avs_writedata,
                                                         avs_byteenable);
          default: begin
          end
        endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cap_mask              <= `EFR_CAP_RST;
      component_select_mask <= 32'h0000_0000;
      gpr_ofs               <= `EFR_GPR_OFS_RST;
      flags_word            <= 64'h0000_0000_0000_0000;
      ppd_addr              <= 64'h0000_0000_0000_0000;
      rec_count             <= 32'h0000_0000;
      drop_count            <= 32'h0000_0000;
      last_rec              <= '0;
      rec_out               <= '0;
      acc_done              <= 1'b0;
      rdata                 <= 32'h0000_0000;
      avs_readdata          <= 32'h0000_0000;
      avs_waitrequest       <= 1'b1;
    end else begin
      cap_mask              <= next_cap_mask;
      component_select_mask <= next_sel;
      gpr_ofs               <= next_gpr_ofs;
      flags_word            <= next_flags_word;
      ppd_addr              <= next_ppd_addr;
      rec_count             <= next_rec_count;
      drop_count            <= next_drop_count;
      last_rec              <= next_last_rec;
      rec_out               <= next_rec_out;
      acc_done              <= next_acc_done;
      rdata                 <= next_rdata;
      avs_readdata          <= next_rdata;
      avs_waitrequest       <= next_wait;
    end
  end
endmodule

// File: efr_recorder_chk.sv
`timescale 1ns/1ps
module efr_recorder_chk
  import efr_pkg::*;
(
  // clock and reset
  input wire logic     core_clk,
  input wire logic     sys_rst,
  // bus handshake
  input wire logic     avs_read,
  input wire logic     avs_write,
  input wire logic     avs_waitrequest,
  // fault side
  input efr_fault_in_t fault_in,
  input efr_record_t   rec_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire pf_in = fault_in.valid && fault_in.kind == EFR_PF;
  wire gp_in = fault_in.valid && fault_in.kind == EFR_GP;

  property p_rsv_zero; rec_out.valid |-> rec_out.reserved == 32'h0000_0000; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("record spare word not zero");
  property p_pf_code;
    pf_in && fault_in.user |=> !rec_out.valid || rec_out.err_code == {16'h0000,
      $past(fault_in.map_fault), 9'h000, $past(fault_in.pkey), $past(fault_in.fetch),
      $past(fault_in.rsvd_bit), 1'b1, $past(fault_in.write), $past(fault_in.present)};
  endproperty
  a_pf_code: assert property (p_pf_code) else $error("page fault code wrong");
  property p_pf_addr;
    pf_in && fault_in.user |=> !rec_out.valid || rec_out.lin_addr == $past(fault_in.lin_addr);
  endproperty
  a_pf_addr: assert property (p_pf_addr) else $error("page fault address wrong");
  property p_gp_addr; gp_in |=> rec_out.lin_addr == 64'h0000_0000_0000_0000; endproperty
  a_gp_addr: assert property (p_gp_addr) else $error("protection fault address set");
  property p_gp_code;
    gp_in |=> !rec_out.valid || rec_out.err_code == {16'h0000, $past(fault_in.gp_code)};
  endproperty
  a_gp_code: assert property (p_gp_code) else $error("protection fault code wrong");
  property p_user_drop; pf_in && !fault_in.user |=> !rec_out.valid; endproperty
  a_user_drop: assert property (p_user_drop) else $error("supervisor fault recorded");
  property p_cause;
    rec_out.valid |-> $past(fault_in.valid) && $past(fault_in.kind) != EFR_NONE;
  endproperty
  a_cause: assert property (p_cause) else $error("record without a fault");
  property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_one_cyc; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one_cyc: assert property (p_one_cyc) else $error("bus answer held too long");
  c_pf: cover property (pf_in ##1 rec_out.valid);
  c_gp: cover property (gp_in ##1 rec_out.valid);
  c_rd: cover property (avs_read && !avs_waitrequest);
endmodule

bind efr_recorder efr_recorder_chk i_efr_recorder_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .fault_in(fault_in), .rec_out(rec_out));

// File: efr_frame_model.sv
`timescale 1ns/1ps
module efr_frame_model
  import efr_pkg::*;
(
  // clock and record from the device
  input wire logic    core_clk,
  input efr_record_t  rec_out,
  // software view of the last record
  output logic [63:0] seen_addr,
  output logic [31:0] seen_err,
  output logic [31:0] seen_rsv,
  output logic [31:0] seen_ofs
);
  logic [7:0]   frame [0:1023];
  logic [127:0] flat;
  logic [127:0] back;
  assign flat = {rec_out.reserved, rec_out.err_code, rec_out.lin_addr};
  // little-endian bytes, as software reads the frame
  always @(posedge core_clk) begin
    if (rec_out.valid) begin
      for (int i = 0; i < 16; i++) begin
        frame[10'(rec_out.frame_ofs + i)] <= flat[i * 8 +: 8];
      end
      seen_ofs <= rec_out.frame_ofs;
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      back[i * 8 +: 8] = frame[10'(seen_ofs + i)];
    end
  end
  assign {seen_rsv, seen_err, seen_addr} = back;
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb
  import efr_pkg::*;
;
  logic          core_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [5:0]    avs_address = 6'h00;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = 32'h0000_0000;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  efr_fault_in_t fault_in = '0;
  efr_record_t   rec_out;
  logic [63:0]   seen_addr;
  logic [31:0]   seen_err, seen_rsv, seen_ofs, q;
  int            n_mismatch = 0;
  int            checks_done = 0;
  always #50 core_clk = ~core_clk;
  efr_recorder i_efr_recorder (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_in(fault_in), .rec_out(rec_out));
  efr_frame_model i_efr_frame_model (.core_clk(core_clk), .rec_out(rec_out),
    .seen_addr(seen_addr), .seen_err(seen_err), .seen_rsv(seen_rsv), .seen_ofs(seen_ofs));
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0000_0000);
    chk(s, e, q);
  endtask
  // b packs map, key, fetch, reserved-bit, user, write, present
  task automatic flt(input efr_fault_t k, input logic [6:0] b, input logic [15:0] g,
                     input logic ex, input logic [31:0] ofs);
    efr_fault_in_t f;
    f = '0;
    {f.valid, f.kind, f.lin_addr, f.gp_code} = {1'b1, k, 64'h1234_5678_9ABC_D008, g};
    {f.map_fault, f.pkey, f.fetch, f.rsvd_bit, f.user, f.write, f.present} = b;
    @(posedge core_clk);
    fault_in <= f;
    @(posedge core_clk);
    fault_in <= '0;
    #1;
    chk("rec_valid", ex, rec_out.valid);
    if (ex) begin
      @(posedge core_clk);
      #1;
      chk("rec_addr", k == EFR_PF ? f.lin_addr : 64'h0000_0000_0000_0000, seen_addr);
      chk("rec_err", k == EFR_PF ? {16'h0000, b[6], 9'h000, b[5:3], 1'b1, b[1:0]}
          : {16'h0000, g}, seen_err);
      chk("rec_rsv", 32'h0000_0000, seen_rsv);
      chk("rec_ofs", ofs, seen_ofs);
    end
  endtask
  task automatic t_regs();
    rd(6'h00, 32'h0000_0001, "cap");
    rd(6'h01, 32'h0000_0000, "select");
    rd(6'h02, 32'h0000_0100, "gpr_ofs");
    rd(6'h03, 32'h0000_0000, "misc_size");
    bus(1'b1, 6'h11, 32'h0000_0001);
    rd(6'h01, 32'h0000_0000, "select_alias");
    bus(1'b1, 6'h05, 32'hFFFF_FFFF);
    rd(6'h05, 32'h0000_0000, "status_ro");
    rd(6'h3F, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_record();
    flt(EFR_PF, 7'h07, 16'h0000, 1'b0, 32'h0000_0000);
    bus(1'b1, 6'h01, 32'h0000_0001);
    rd(6'h03, 32'h0000_0010, "misc_size");
    rd(6'h04, 32'h0000_00F0, "misc_base");
    flt(EFR_PF, 7'h7F, 16'h0000, 1'b1, 32'h0000_00F0);
    flt(EFR_GP, 7'h00, 16'hABCD, 1'b1, 32'h0000_00F0);
    flt(EFR_PF, 7'h79, 16'h0000, 1'b0, 32'h0000_0000);
    bus(1'b1, 6'h02, 32'h0000_0200);
    flt(EFR_PF, 7'h06, 16'h0000, 1'b1, 32'h0000_01F0);
    bus(1'b1, 6'h00, 32'h0000_0000);
    rd(6'h03, 32'h0000_0000, "misc_size_nocap");
    flt(EFR_PF, 7'h07, 16'h0000, 1'b0, 32'h0000_0000);
    rd(6'h05, 32'h0003_0003, "status");
  endtask
  task automatic t_flags();
    logic [7:0]  t;
    logic [31:0] lo;
    logic        ok;
    for (int i = 0; i < 8; i++) begin
      t = (i < 6) ? i[7:0] : 8'h02;
      lo = {16'h0000, t, 2'(i == 6), 6'(i * 11)};
      ok = t <= 8'h04 && i < 6;
      bus(1'b1, 6'h0C, i[0] ? 32'h0000_0028 : 32'h0000_0020);
      bus(1'b1, 6'h09, lo);
      bus(1'b1, 6'h0A, {31'h0000_0000, i == 7});
      rd(6'h0B, {t, 16'h0000, !i[0], ok, lo[5:0]}, "decode");
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_record();
    t_flags();
    wrap_up();
  end
endmodule
